// *** src/wwd_defs.svh ***
// Offsets, field positions, reset values and timing constants of the windowed watchdog
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

`define WWD_OFS_RESTART   8'h00
`define WWD_OFS_MODE      8'h04
`define WWD_OFS_STATUS    8'h08
`define WWD_OFS_IRQ_PEND  8'h0C
`define WWD_OFS_IRQ_MASK  8'h10

`define WWD_KEY_MSB       31
`define WWD_KEY_LSB       24
`define WWD_KEY_VALUE     8'hA5
`define WWD_RESTART_BIT   0

`define WWD_UNF_BIT       0
`define WWD_ERR_BIT       1

`define WWD_MODE_RESET    32'h3FFF_2FFF
`define WWD_MASK_RESET    2'h3

`define WWD_PRESCALE      128
`define WWD_SLOW_DIV      763

`define WWD_RESP_OKAY     2'h0
`define WWD_RESP_SLVERR   2'h2

`endif

// *** src/wwd_pkg.sv ***
// Types shared by the windowed watchdog
package wwd_pkg;

  typedef logic [11:0] wwd_count_t;

  // Mode register layout, most significant field first
  typedef struct packed {
    logic [1:0]  unused;
    logic        idle_halt;
    logic        debug_halt;
    wwd_count_t  delta_window_value;
    logic        timer_disable;
    logic        processor_only_reset;
    logic        fault_reset_enable;
    logic        fault_irq_enable;
    wwd_count_t  counter_load_value;
  } wwd_mode_s;

  // Fault events in status bit order
  typedef struct packed {
    logic window_error_flag;
    logic underflow_flag;
  } wwd_flags_s;

endpackage

// *** src/wwd_top.sv ***
// Windowed watchdog timer with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "wwd_defs.svh"

module wwd_top #(
  parameter int SLOW_DIV = `WWD_SLOW_DIV,
  parameter int PRESCALE = `WWD_PRESCALE
) (
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  // AXI4-Lite write address and data
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [7:0]           i_awaddr,
  input  wire logic [2:0]           i_awprot,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  // AXI4-Lite write response
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  output logic [1:0]                o_bresp,
  // AXI4-Lite read
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  input  wire logic [7:0]           i_araddr,
  input  wire logic [2:0]           i_arprot,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  // Processor state pins
  input  wire logic                 i_debug_state,
  input  wire logic                 i_idle_mode,
  // Fault outputs
  output logic                      o_irq,
  output logic                      o_fault,
  output logic                      o_proc_only_reset,
  output wwd_pkg::wwd_flags_s       o_flags
);
  import wwd_pkg::*;

  localparam int SDW = $clog2(SLOW_DIV);
  localparam int PSW = $clog2(PRESCALE);

  // Divider needs two states, prescaler wraps only at a power of two
  if (SLOW_DIV < 2 || PRESCALE < 2 || (1 << PSW) != PRESCALE)
  begin : g_param_check
    $error("wwd_top: SLOW_DIV must be >= 2 and PRESCALE a power of two >= 2");
  end

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `WWD_OFS_RESTART) || (addr == `WWD_OFS_MODE) ||
                  (addr == `WWD_OFS_STATUS)  || (addr == `WWD_OFS_IRQ_PEND) ||
                  (addr == `WWD_OFS_IRQ_MASK);
  endfunction

  logic [7:0]   aw_addr_r;
  logic [31:0]  w_data_r;
  logic [3:0]   w_strb_r;
  logic         wr_go;
  logic         rd_go;
  logic         stat_rd;
  wwd_mode_s    mode_r;
  logic         mode_locked_r;
  wwd_count_t   count_r;
  wwd_flags_s   status_r;
  wwd_flags_s   pend_r;
  logic [1:0]   mask_r;
  logic [SDW-1:0] slow_cnt_r;
  logic [PSW-1:0] pres_r;
  logic         slow_en_r;
  logic [1:0]   dbg_sync_r;
  logic [1:0]   idle_sync_r;
  logic         running;
  logic         tick;
  logic         key_ok;
  logic         restart_req;
  logic         restart_ok;
  logic         mode_wr;
  wwd_flags_s   evt;

  // Pins from the processor domain, two flops before use
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dbg_sync_r  <= 2'h0;
      idle_sync_r <= 2'h0;
    end
    else
    begin
      dbg_sync_r  <= {dbg_sync_r[0], i_debug_state};
      idle_sync_r <= {idle_sync_r[0], i_idle_mode};
    end
  end

  // Write channel: address and data taken in either order
  assign wr_go = !o_awready && !o_wready && !o_bvalid;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= `WWD_RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_addr_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= addr_mapped(aw_addr_r) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
      end
      if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Partial-word writes to restart and mode are ignored: key and fields span several lanes
  assign key_ok      = w_data_r[`WWD_KEY_MSB:`WWD_KEY_LSB] == `WWD_KEY_VALUE;
  assign restart_req = wr_go && (aw_addr_r == `WWD_OFS_RESTART) && (w_strb_r == 4'hF) &&
                       key_ok && w_data_r[`WWD_RESTART_BIT];
  assign restart_ok  = restart_req && (count_r <= mode_r.delta_window_value);
  assign mode_wr     = wr_go && (aw_addr_r == `WWD_OFS_MODE) && (w_strb_r == 4'hF) &&
                       !mode_locked_r;

  // Read channel
  assign rd_go   = i_arvalid && o_arready;
  assign stat_rd = rd_go && (i_araddr == `WWD_OFS_STATUS);

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `WWD_RESP_OKAY;
    end
    else if (rd_go)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= addr_mapped(i_araddr) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
      case (i_araddr)
        `WWD_OFS_MODE:     o_rdata <= mode_r;
        `WWD_OFS_STATUS:   o_rdata <= {30'h0000_0000, status_r};
        `WWD_OFS_IRQ_PEND: o_rdata <= {30'h0000_0000, pend_r};
        `WWD_OFS_IRQ_MASK: o_rdata <= {30'h0000_0000, mask_r};
        default:           o_rdata <= 32'h0000_0000;
      endcase
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Mode register, write once
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_r        <= `WWD_MODE_RESET;
      mode_locked_r <= 1'b0;
    end
    else if (mode_wr)
    begin
      mode_r        <= w_data_r;
      mode_locked_r <= 1'b1;
    end
  end

  assign running = !mode_r.timer_disable &&
                   !(mode_r.debug_halt && dbg_sync_r[1]) &&
                   !(mode_r.idle_halt && idle_sync_r[1]);

  // Slow clock enable, then the divide-by-128 prescaler
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      slow_cnt_r <= '0;
      slow_en_r  <= 1'b0;
    end
    else
    begin
      slow_en_r  <= (slow_cnt_r == SDW'(SLOW_DIV - 1));
      slow_cnt_r <= (slow_cnt_r == SDW'(SLOW_DIV - 1)) ? '0 : slow_cnt_r + 1'b1;
    end
  end

  assign tick = running && slow_en_r && (pres_r == PSW'(PRESCALE - 1));

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pres_r <= '0;
    else if (restart_ok || mode_wr)
      pres_r <= '0;
    else if (running && slow_en_r)
      pres_r <= pres_r + 1'b1;
  end

  // Down counter; reloads after an underflow so faults repeat each period
  assign evt.underflow_flag    = tick && (count_r == 12'h000);
  assign evt.window_error_flag = restart_req && !restart_ok;

  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      count_r <= wwd_count_t'(`WWD_MODE_RESET);
    else if (mode_wr)
      count_r <= w_data_r[11:0];
    else if (restart_ok || evt.underflow_flag)
      count_r <= mode_r.counter_load_value;
    else if (tick)
      count_r <= count_r - 12'h001;
  end

  // Sticky flags; a new event beats the clearing read
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      status_r <= '0;
      pend_r   <= '0;
      mask_r   <= `WWD_MASK_RESET;
    end
    else
    begin
      status_r <= (stat_rd ? '0 : status_r) | evt;
      pend_r   <= (stat_rd ? '0 :
                   (wr_go && aw_addr_r == `WWD_OFS_IRQ_PEND ? pend_r & ~w_data_r[1:0]
                                                            : pend_r)) | evt;
      if (wr_go && aw_addr_r == `WWD_OFS_IRQ_MASK && w_strb_r[0])
        mask_r <= w_data_r[1:0];
    end
  end

  // Fault outputs to reset controller and interrupt logic
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_fault           <= 1'b0;
      o_proc_only_reset <= 1'b0;
      o_irq             <= 1'b0;
      o_flags           <= '0;
    end
    else
    begin
      o_fault <= (stat_rd ? 1'b0 : o_fault) |
                 (mode_r.fault_reset_enable && (|evt));
      o_proc_only_reset <= mode_r.processor_only_reset;
      o_irq   <= mode_r.fault_irq_enable && !stat_rd &&
                 (|(pend_r & mask_r));
      o_flags <= status_r;
    end
  end

endmodule
`default_nettype wire

// *** test/wwd_sys_model.sv ***
// Reset controller and interrupt sink model that tallies watchdog requests
`timescale 1ns/100ps
`default_nettype none
module wwd_sys_model (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  // Requests from the watchdog
  input  wire logic i_fault,
  input  wire logic i_proc_only,
  input  wire logic i_irq,
  // Tallies
  output int        o_n_full,
  output int        o_n_proc,
  output int        o_n_irq
);
  logic fault_r;
  logic irq_r;
  // Only tallies; resetting the watchdog here would hide its status
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
    begin
      fault_r  <= 1'b0;
      irq_r    <= 1'b0;
      o_n_full <= 0;
      o_n_proc <= 0;
      o_n_irq  <= 0;
    end
    else
    begin
      fault_r <= i_fault;
      irq_r   <= i_irq;
      if (i_fault && !fault_r && i_proc_only)
        o_n_proc <= o_n_proc + 1;
      if (i_fault && !fault_r && !i_proc_only)
        o_n_full <= o_n_full + 1;
      if (i_irq && !irq_r)
        o_n_irq <= o_n_irq + 1;
    end
endmodule
`default_nettype wire

// *** test/wwd_top_props.sv ***
// Checker for the watchdog fault, flag and mode behaviour
`timescale 1ns/100ps
`default_nettype none
module wwd_top_props (
  // Clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_arst_n,
  // Read channel
  input  wire logic                i_arvalid,
  input  wire logic                o_arready,
  input  wire logic [7:0]          i_araddr,
  input  wire logic                o_rvalid,
  input  wire logic [31:0]         o_rdata,
  // Fault outputs
  input  wire logic                o_irq,
  input  wire logic                o_fault,
  input  wire logic                o_proc_only_reset,
  input  wire wwd_pkg::wwd_flags_s o_flags
);
  import wwd_pkg::*;
  logic        rd_st_r;
  logic        rd_md_r;
  logic [2:0]  since_rd_r;
  logic [31:0] md_r;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
    begin
      rd_st_r    <= 1'b0;
      rd_md_r    <= 1'b0;
      since_rd_r <= 3'h7;
      md_r       <= 32'h3FFF_2FFF;
    end
    else
    begin
      if (i_arvalid && o_arready)
      begin
        rd_st_r <= i_araddr == 8'h08;
        rd_md_r <= i_araddr == 8'h04;
      end
      if (i_arvalid && o_arready && i_araddr == 8'h08)
        since_rd_r <= 3'h0;
      else if (since_rd_r != 3'h7)
        since_rd_r <= since_rd_r + 3'h1;
      if (o_rvalid && rd_md_r)
        md_r <= o_rdata;
    end
  a_irq_gated: assert property (o_rvalid && rd_md_r && !o_rdata[12] |-> !o_irq)
    else $error("irq high with interrupt disabled");
  a_rst_type: assert property (o_rvalid && rd_md_r |-> o_proc_only_reset == o_rdata[14])
    else $error("reset type differs from mode");
  a_unf_sticky: assert property ($fell(o_flags.underflow_flag) |-> since_rd_r <= 3'h3)
    else $error("underflow flag dropped without read");
  a_err_sticky: assert property ($fell(o_flags.window_error_flag) |-> since_rd_r <= 3'h3)
    else $error("error flag dropped without read");
  a_unf_fault: assert property (
    $rose(o_flags.underflow_flag) && md_r[13] && since_rd_r > 3'h3 |-> o_fault)
    else $error("underflow without fault line");
  a_err_fault: assert property (
    $rose(o_flags.window_error_flag) && md_r[13] && since_rd_r > 3'h3 |-> o_fault)
    else $error("window error without fault line");
  a_read_clears: assert property ($rose(o_rvalid) && rd_st_r |-> !o_irq)
    else $error("irq kept after status read");
  a_mode_once: assert property (
    o_rvalid && rd_md_r && md_r != 32'h3FFF_2FFF |-> o_rdata == md_r)
    else $error("mode changed after first write");
endmodule
bind wwd_top wwd_top_props wwd_top_props_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
  .o_rdata(o_rdata), .o_irq(o_irq), .o_fault(o_fault),
  .o_proc_only_reset(o_proc_only_reset), .o_flags(o_flags));
`default_nettype wire

// *** test/tb.sv ***
// Register-level testbench of the windowed watchdog
`timescale 1ns/100ps
`default_nettype none
module tb;
  import wwd_pkg::*;
  localparam logic [31:0] MODE_V = 32'h0002_700A;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        bre = 1'b0;
  logic        arv = 1'b0;
  logic        rre = 1'b0;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'hF;
  logic        dbg = 1'b0;
  logic        idl = 1'b0;
  logic [1:0]  brsp;
  logic [31:0] rdt;
  logic [1:0]  br;
  logic [1:0]  rr;
  logic [1:0]  rrsp;
  logic        awr, wrd, bv, arr, rv, irq, flt, por;
  wwd_flags_s  flg;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          t, nf, np, ni;
  always #20 clk = ~clk;
  wwd_top #(.SLOW_DIV(2), .PRESCALE(4)) wwd_top_i (.i_clk_sys(clk), .i_arst_n(rst_n),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_awprot(3'h0), .i_wvalid(wv),
    .o_wready(wrd), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv), .i_bready(bre),
    .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .i_arprot(3'h0),
    .o_rvalid(rv), .i_rready(rre), .o_rdata(rdt), .o_rresp(rr), .i_debug_state(dbg),
    .i_idle_mode(idl), .o_irq(irq), .o_fault(flt), .o_proc_only_reset(por), .o_flags(flg));
  wwd_sys_model wwd_sys_model_i (.i_clk_sys(clk), .i_arst_n(rst_n), .i_fault(flt),
    .i_proc_only(por), .i_irq(irq), .o_n_full(nf), .o_n_proc(np), .o_n_irq(ni));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
    end
    while (!bv);
    brsp = br;
    bre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
    end
    while (!rv);
    rrsp = rr;
    check(rdt, e);
    rre <= 1'b0;
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Cycle ceiling well above the roughly seven hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      complete_run;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h04, 32'h3FFF_2FFF);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    check({30'h0, rrsp}, 32'h2);
    wr(8'h40, 32'h0);
    check({30'h0, brsp}, 32'h2);
    wr(8'h04, MODE_V);
    check({30'h0, brsp}, 32'h0);
    wr(8'h04, 32'h0);
    rd(8'h04, MODE_V);
    wr(8'h00, 32'h5A00_0001);
    wr(8'h00, 32'hA500_0000);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'hA500_0001);
    repeat (2) @(posedge clk);
    check({31'h0, flt}, 32'h1);
    check({31'h0, por}, 32'h1);
    check({30'h0, flg}, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h3);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(8'h0C, 32'h2);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd(8'h08, 32'h2);
    check({31'h0, flt}, 32'h0);
    rd(8'h08, 32'h0);
    t = 0;
    while (!flt && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    rd(8'h08, 32'h1);
    // Lands inside the window, before the next underflow
    repeat (68) @(posedge clk);
    wr(8'h00, 32'hA500_0001);
    repeat (40) @(posedge clk);
    rd(8'h08, 32'h0);
    rd(8'h04, MODE_V);
    check(32'(np), 32'h2);
    check(32'(nf), 32'h0);
    check(32'(ni), 32'h3);
    // Mid-run reset with the debug pin up; reset mode already halts
    dbg <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ws <= 4'h3;
    wr(8'h04, 32'h3002_300A);
    ws <= 4'hF;
    rd(8'h04, 32'h3FFF_2FFF);
    wr(8'h04, 32'h3002_300A);
    repeat (120) @(posedge clk);
    check({31'h0, flt}, 32'h0);
    dbg <= 1'b0;
    idl <= 1'b1;
    repeat (120) @(posedge clk);
    check({31'h0, flt}, 32'h0);
    idl <= 1'b0;
    t = 0;
    while (!flt && t < 300)
    begin
      @(posedge clk);
      t++;
    end
    repeat (2) @(posedge clk);
    check({31'h0, flt}, 32'h1);
    check(32'(nf), 32'h1);
    // Reset while the fault line stands, then a disabled timer
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check({31'h0, flt}, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h04, 32'h0002_B00A);
    repeat (120) @(posedge clk);
    check({31'h0, flt}, 32'h0);
    wr(8'h00, 32'hA500_0001);
    rd(8'h08, 32'h2);
    complete_run;
  end
endmodule
`default_nettype wire
